// ### hdl/ssc_pkg.sv
// Constants, offsets and types shared by the serial clock config files.
// Assumes a 32-bit APB master reaching registers at four times the index.
`default_nettype none

package ssc_pkg;

	// ****************************************
	// Register indexes; byte address is index times four.
	// ****************************************
	localparam logic [15:0] CFG_IDX  = 16'h1FB7;
	localparam logic [15:0] AUX_IDX  = 16'h1FB8;
	localparam logic [15:0] STAT_IDX = 16'h1FB9;
	localparam logic [15:0] CLR_IDX  = 16'h1FBA;
	localparam logic [15:0] EN_IDX   = 16'h1FBB;

	// ****************************************
	// Field positions and reset values.
	// ****************************************
	localparam int CFG_CLOCK_POLARITY_SELECT  = 0;
	localparam int CFG_CLOCK_PHASE_SELECT  = 1;
	localparam int CFG_PEND  = 2;
	localparam int CFG_IRQEN = 3;
	localparam int CFG_MODE  = 4;
	localparam int AUX_CLOCK_POLARITY_SELECT  = 0;
	localparam int AUX_CLOCK_PHASE_SELECT  = 1;
	localparam int AUX_HS    = 2;
	localparam int AUX_MST   = 3;
	localparam int AUX_START = 4;
	localparam int IRQ_CONT  = 0;
	localparam int IRQ_DONE  = 1;
	localparam logic [4:0] CFG_RST = 5'h00;
	localparam logic [3:0] AUX_RST = 4'h0;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ****************************************
	// Counts of cycles and edges.
	// ****************************************
	localparam int HALF_DIV_DEF = 4;
	localparam int EDGES_DEF    = 16;

	typedef enum logic [1:0] {
		SSC_STD   = 2'b00,
		SSC_DUP   = 2'b01,
		SSC_CHSEL = 2'b10,
		SSC_RSV   = 2'b11
	} ssc_mode_t;

	typedef enum logic [1:0] {
		SSC_IDLE = 2'b00,
		SSC_RUN  = 2'b01
	} ssc_state_t;

endpackage : ssc_pkg

`default_nettype wire

// ### hdl/ssc_edge_if.sv
// Interface between the register block and the clock edge engine.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none

interface ssc_edge_if;
	logic master_en;
	logic idle_level;
	logic shift_rise;
	logic sample_rise;
	logic start;
	logic link_clk;
	logic busy;
	logic done;
	logic sclk;
	logic shift_pulse;
	logic sample_pulse;

	modport engine (input master_en, idle_level, shift_rise, sample_rise,
		start, link_clk, output busy, done, sclk, shift_pulse, sample_pulse);
	modport ctrl (output master_en, idle_level, shift_rise, sample_rise,
		start, link_clk, input busy, done, sclk, shift_pulse, sample_pulse);
endinterface : ssc_edge_if

`default_nettype wire

// ### hdl/ssc_clk_edge.sv
// Serial clock generator and edge strobe engine for channel 1.
// Assumes link_clk is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none

module ssc_clk_edge #(
	parameter int HALF_DIV = ssc_pkg::HALF_DIV_DEF,
	parameter int EDGES    = ssc_pkg::EDGES_DEF
) (
	input wire logic      pclk,
	input wire logic      presetn,
	ssc_edge_if.engine    e
);
	localparam int DW = $clog2(HALF_DIV + 1);

	ssc_pkg::ssc_state_t state_reg;
	logic [DW-1:0]       div_reg;
	logic [4:0]          edge_reg;
	logic                link_prev_reg;
	logic                tick;
	logic                last;
	logic                run;
	logic                edge_v;
	logic                edge_r;

	assign run    = (state_reg == ssc_pkg::SSC_RUN);
	assign tick   = run && (div_reg == DW'(HALF_DIV - 1));
	assign last   = (edge_reg == 5'(EDGES - 1));
	assign e.busy = run;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ssc_pkg::SSC_IDLE;
		end else begin
			case (state_reg)
				ssc_pkg::SSC_IDLE: begin
					if (e.start) begin
						state_reg <= ssc_pkg::SSC_RUN;
					end
				end
				ssc_pkg::SSC_RUN: begin
					if (tick && last) begin
						state_reg <= ssc_pkg::SSC_IDLE;
					end
				end
				default: begin
					state_reg <= ssc_pkg::SSC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg  <= '0;
			edge_reg <= 5'h00;
		end else if (!run || tick) begin
			div_reg  <= '0;
			edge_reg <= run ? edge_reg + 5'h01 : 5'h00;
		end else begin
			div_reg  <= div_reg + DW'(1);
		end
	end

	// Idle level is held whenever no transfer runs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			e.sclk <= 1'b0;
		end else if (!run) begin
			e.sclk <= e.idle_level;
		end else if (tick) begin
			e.sclk <= ~e.sclk;
		end
	end

	always_comb begin
		if (e.master_en) begin
			edge_v = tick;
			edge_r = ~e.sclk;
		end else begin
			edge_v = e.link_clk ^ link_prev_reg;
			edge_r = e.link_clk;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_prev_reg  <= 1'b0;
			e.shift_pulse  <= 1'b0;
			e.sample_pulse <= 1'b0;
			e.done         <= 1'b0;
		end else begin
			link_prev_reg  <= e.link_clk;
			e.shift_pulse  <= edge_v && (edge_r == e.shift_rise);
			e.sample_pulse <= edge_v && (edge_r == e.sample_rise);
			e.done         <= tick && last;
		end
	end

	idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(!run) |-> e.sclk == $past(e.idle_level))
		else $error("Serial clock left idle level outside a transfer.");

	shift_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		e.shift_pulse && $past(e.master_en) |-> e.sclk == $past(e.shift_rise))
		else $error("Shift strobe on the wrong clock edge.");

endmodule : ssc_clk_edge

`default_nettype wire

// ### hdl/ssc_top.sv
// Channel 1 serial clock configuration, contention flag and APB registers.
// Assumes a 50 MHz pclk and pins that arrive asynchronous to it.
//
// Notes on behaviour
// - Config register holds mode, contention irq enable, phase, polarity; resets zero.
// - Mode bits 00 standard, 01 duplex, 10 channel-select half-duplex.
// - In channel-select master use, external select activation sets pending flag.
// - Pending flag only matters in channel-select master use, else ignored.
// - Irq enable set also raises channel 0 serial interrupt pending bit.
// - Transmit edge: 00 low fall, 01 high rise, 10 low rise, 11 high fall.
// - Receive edge: 00 low rise, 01 high fall, 10 low fall, 11 high rise.
// - Duplex and channel-select modes use channel 0 phase and polarity.
// - Handshaking transfers ignore channel 1 phase and polarity bits.
`timescale 1ns/1ps
`default_nettype none

module ssc_top #(
	parameter int HALF_DIV = ssc_pkg::HALF_DIV_DEF,
	parameter int EDGES    = ssc_pkg::EDGES_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        channel_select_pin_n,
	input  wire logic        serial_clock_ch1_in,
	output var  logic        serial_clock_ch1_out,
	output var  logic        serial_clock_ch1_oe,
	output var  logic        shift_strobe,
	output var  logic        sample_strobe,
	output var  logic        irq
);

	// ****************************************
	// Helpers.
	// ****************************************
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] idx);
		return a == {idx[13:0], 2'b00};
	endfunction : hit

	function automatic logic edge_rising(input logic clock_phase_select,
		input logic clock_polarity_select, input logic tx);
		return tx ? (clock_phase_select ^ clock_polarity_select) : ~(clock_phase_select ^ clock_polarity_select);
	endfunction : edge_rising

	ssc_edge_if e ();

	logic [1:0]  sync1_reg;
	logic [1:0]  sync2_reg;
	logic [1:0]  pins;
	logic        chs_prev_reg;
	logic        chs_fall;
	logic [4:0]  cfg_reg;
	logic        pend_reg;
	logic [3:0]  aux_reg;
	logic        start_reg;
	logic [1:0]  stat_reg;
	logic [1:0]  stat_next;
	logic [1:0]  en_reg;
	logic        irq_reg;
	logic        oe_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;
	logic        setup;
	logic        wr;
	logic        mapped;
	logic        cfg_wr;
	logic        aux_wr;
	logic        cs_master;
	logic        pend_set;
	logic [1:0]  mode;
	logic        eff_clock_phase_select;
	logic        eff_clock_polarity_select;

	// ****************************************
	// Pin synchronisers.
	// ****************************************
	assign pins = {serial_clock_ch1_in, channel_select_pin_n};

	// The select pin rests high and the link clock low, as after reset.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_reg[i] <= (i == 0);
					sync2_reg[i] <= (i == 0);
				end else begin
					sync1_reg[i] <= pins[i];
					sync2_reg[i] <= sync1_reg[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chs_prev_reg <= 1'b1;
		end else begin
			chs_prev_reg <= sync2_reg[0];
		end
	end

	assign chs_fall = chs_prev_reg & ~sync2_reg[0];

	// ****************************************
	// APB decode.
	// ****************************************
	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pready_reg & pwrite;
	assign mapped = hit(paddr, ssc_pkg::CFG_IDX)
		| hit(paddr, ssc_pkg::AUX_IDX)
		| hit(paddr, ssc_pkg::STAT_IDX)
		| hit(paddr, ssc_pkg::CLR_IDX)
		| hit(paddr, ssc_pkg::EN_IDX);
	assign cfg_wr = wr & hit(paddr, ssc_pkg::CFG_IDX);
	assign aux_wr = wr & hit(paddr, ssc_pkg::AUX_IDX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_reg <= 32'h00000000;
			if (hit(paddr, ssc_pkg::CFG_IDX)) begin
				prdata_reg[7:0] <= {2'b00, cfg_reg[4:2], pend_reg,
					cfg_reg[1:0]};
			end
			if (hit(paddr, ssc_pkg::AUX_IDX)) begin
				prdata_reg[4:0] <= {e.busy, aux_reg};
			end
			if (hit(paddr, ssc_pkg::STAT_IDX)) begin
				prdata_reg[1:0] <= stat_reg;
			end
			if (hit(paddr, ssc_pkg::EN_IDX)) begin
				prdata_reg[1:0] <= en_reg;
			end
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ****************************************
	// Configuration registers.
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= ssc_pkg::CFG_RST;
		end else if (cfg_wr) begin
			cfg_reg <= {pwdata[ssc_pkg::CFG_MODE+1 -: 3],
				pwdata[ssc_pkg::CFG_CLOCK_PHASE_SELECT -: 2]};
		end
	end

	assign mode = cfg_reg[4:3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_reg   <= ssc_pkg::AUX_RST;
			start_reg <= 1'b0;
		end else begin
			start_reg <= aux_wr & pwdata[ssc_pkg::AUX_START]
				& pwdata[ssc_pkg::AUX_MST];
			if (aux_wr) begin
				aux_reg <= pwdata[3:0];
			end
		end
	end

	// ****************************************
	// Contention detection.
	// ****************************************
	assign cs_master = (mode == ssc_pkg::SSC_CHSEL)
		& aux_reg[ssc_pkg::AUX_MST];
	assign pend_set = cs_master & chs_fall;

	// Setting wins over a software write of zero in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_reg <= 1'b0;
		end else if (pend_set) begin
			pend_reg <= 1'b1;
		end else if (cfg_wr && !pwdata[ssc_pkg::CFG_PEND]) begin
			pend_reg <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt status, enable and clear.
	// ****************************************
	always_comb begin
		stat_next = stat_reg;
		if (wr && hit(paddr, ssc_pkg::CLR_IDX)) begin
			stat_next = stat_reg & ~pwdata[1:0];
		end
		stat_next[ssc_pkg::IRQ_CONT] = stat_next[ssc_pkg::IRQ_CONT]
			| (pend_set & cfg_reg[2]);
		stat_next[ssc_pkg::IRQ_DONE] = stat_next[ssc_pkg::IRQ_DONE]
			| e.done;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= ssc_pkg::IRQ_RST;
			en_reg   <= ssc_pkg::IRQ_RST;
			irq_reg  <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq_reg  <= |(stat_reg & en_reg);
			if (wr && hit(paddr, ssc_pkg::EN_IDX)) begin
				en_reg <= pwdata[1:0];
			end
		end
	end

	assign irq = irq_reg;

	// ****************************************
	// Effective clock phase and polarity.
	// ****************************************
	always_comb begin
		if (mode == ssc_pkg::SSC_DUP || mode == ssc_pkg::SSC_CHSEL) begin
			eff_clock_phase_select = aux_reg[ssc_pkg::AUX_CLOCK_PHASE_SELECT];
			eff_clock_polarity_select = aux_reg[ssc_pkg::AUX_CLOCK_POLARITY_SELECT];
		end else if (aux_reg[ssc_pkg::AUX_HS]) begin
			eff_clock_phase_select = 1'b0;
			eff_clock_polarity_select = 1'b0;
		end else begin
			eff_clock_phase_select = cfg_reg[ssc_pkg::CFG_CLOCK_PHASE_SELECT];
			eff_clock_polarity_select = cfg_reg[ssc_pkg::CFG_CLOCK_POLARITY_SELECT];
		end
	end

	assign e.master_en   = aux_reg[ssc_pkg::AUX_MST];
	assign e.idle_level  = eff_clock_polarity_select;
	assign e.shift_rise  = edge_rising(eff_clock_phase_select, eff_clock_polarity_select, 1'b1);
	assign e.sample_rise = edge_rising(eff_clock_phase_select, eff_clock_polarity_select, 1'b0);
	assign e.start       = start_reg;
	assign e.link_clk    = sync2_reg[1];

	ssc_clk_edge #(
		.HALF_DIV (HALF_DIV),
		.EDGES    (EDGES)
	) u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.e       (e.engine)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= aux_reg[ssc_pkg::AUX_MST];
		end
	end

	assign serial_clock_ch1_oe  = oe_reg;
	assign serial_clock_ch1_out = e.sclk;
	assign shift_strobe         = e.shift_pulse;
	assign sample_strobe        = e.sample_pulse;

	// ****************************************
	// Assertions.
	// ****************************************
	cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit(paddr, ssc_pkg::CFG_IDX) |=>
		prdata[7:6] == 2'b00 && prdata[5:4] == $past(mode))
		else $error("Config read returned wrong fields.");

	pend_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		pend_set |=> pend_reg ##1 pend_reg || $past(cfg_wr))
		else $error("Contention flag not set or lost.");

	pend_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pend_reg) |-> $past(cs_master && chs_fall))
		else $error("Contention flag set outside channel-select master use.");

	irq_link_a: assert property (@(posedge pclk) disable iff (!presetn)
		pend_set && cfg_reg[2] |=> stat_reg[0] ##1 irq || !en_reg[0])
		else $error("Contention did not raise the channel 0 interrupt.");

	irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stat_reg[0]) |-> $past(pend_set && cfg_reg[2]))
		else $error("Channel 0 interrupt raised without enabled contention.");

	ch0_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == ssc_pkg::SSC_DUP |-> e.idle_level == aux_reg[0]
		&& e.shift_rise == (aux_reg[1] ^ aux_reg[0]))
		else $error("Duplex mode did not follow channel 0 clock settings.");

	hs_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == ssc_pkg::SSC_STD && aux_reg[2] |-> !e.idle_level
		&& !e.shift_rise && e.sample_rise)
		else $error("Handshaking used channel 1 phase or polarity.");

	std_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == ssc_pkg::SSC_STD && !aux_reg[2] |->
		e.sample_rise == (cfg_reg[1] == cfg_reg[0])
		&& e.sample_rise != e.shift_rise)
		else $error("Receive edge decode does not match phase and polarity.");

	cfg_write_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg_wr |=> mode == $past(pwdata[5:4])
		&& cfg_reg[2] == $past(pwdata[3])
		&& cfg_reg[1:0] == $past(pwdata[1:0]))
		else $error("Config write did not land in its fields.");

	pend_quiet_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		chs_fall && !cs_master && !pend_reg |=> !pend_reg)
		else $error("Select activation set the flag in another operation.");

	chsel_clock_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == ssc_pkg::SSC_CHSEL |-> e.idle_level == aux_reg[0]
		&& e.sample_rise == (aux_reg[1] == aux_reg[0]))
		else $error("Channel-select mode ignored channel 0 clock settings.");

	std_shift_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == ssc_pkg::SSC_STD && !aux_reg[2] |->
		e.idle_level == cfg_reg[0]
		&& e.shift_rise == (cfg_reg[1] != cfg_reg[0]))
		else $error("Transmit edge or idle level does not match the config.");

endmodule : ssc_top

`default_nettype wire

// ### test/ssc_far_end.sv
// Far-end model: an external serial master that claims and clocks frames.
// Assumes the bench calls claim, park and frame; link clock is off pclk grid.
`timescale 1ns/1ps
`default_nettype none

module ssc_far_end (
	input  wire logic pclk,
	output var  logic chs_n,
	output var  logic link_clk
);
	initial begin
		chs_n = 1'b1;
		link_clk = 1'b0;
	end
	// Pulls the select line low for a few cycles to claim the clock.
	task automatic claim;
		@(posedge pclk);
		chs_n <= 1'b0;
		repeat (6) @(posedge pclk);
		chs_n <= 1'b1;
	endtask : claim
	// Moves the resting clock level well before the next frame starts.
	task automatic park(input logic idle);
		#7;
		link_clk = idle;
		repeat (6) @(posedge pclk);
	endtask : park
	// Sixteen edges 80 ns apart; the clock stands at idle between frames.
	task automatic frame;
		#7;
		repeat (16) #80 link_clk = ~link_clk;
	endtask : frame
endmodule : ssc_far_end

`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the channel 1 serial clock configuration block.
// Assumes ssc_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam logic [15:0] A_CFG  = ssc_pkg::CFG_IDX << 2;
	localparam logic [15:0] A_AUX  = ssc_pkg::AUX_IDX << 2;
	localparam logic [15:0] A_STAT = ssc_pkg::STAT_IDX << 2;
	localparam logic [15:0] A_CLR  = ssc_pkg::CLR_IDX << 2;
	localparam logic [15:0] A_EN   = ssc_pkg::EN_IDX << 2;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, chs_n, lclk, sc_out, sc_oe, sh, sa, irq, e;
	logic        watch, master, exp_rise;
	logic [1:0]  pp;
	int          n_mismatch, samples_checked, n_sh, n_sa, seed, i;

	ssc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_select_pin_n(chs_n),
		.serial_clock_ch1_in(lclk), .serial_clock_ch1_out(sc_out),
		.serial_clock_ch1_oe(sc_oe), .shift_strobe(sh),
		.sample_strobe(sa), .irq(irq));
	ssc_far_end far (.pclk(pclk), .chs_n(chs_n), .link_clk(lclk));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : apb

	// Effective {phase, polarity} of the channel 1 clock.
	function automatic logic [1:0] clk_cfg(input logic [1:0] md,
		input logic hs, input logic [1:0] c, input logic [1:0] a);
		if (md == 2'b01 || md == 2'b10) return a;
		if (hs) return 2'b00;
		return c;
	endfunction : clk_cfg

	// Every strobe in a master transfer must land on its edge kind.
	always @(posedge pclk) begin
		if (watch && sh === 1'b1) begin
			n_sh++;
			if (master) chk({31'h0, sc_out}, {31'h0, exp_rise});
		end
		if (watch && sa === 1'b1) begin
			n_sa++;
			if (master) chk({31'h0, sc_out}, {31'h0, !exp_rise});
		end
	end

	task automatic xfer(input logic [1:0] md, input logic hs,
		input logic [1:0] c, input logic [1:0] a);
		int k;
		master = 1'b1;
		apb(1'b1, A_CFG, {26'h0, md, 2'b00, c});
		apb(1'b1, A_AUX, {27'h0, 2'b01, hs, a});
		pp = clk_cfg(md, hs, c, a);
		exp_rise = pp[1] ^ pp[0];
		repeat (2) @(posedge pclk);
		chk({30'h0, sc_oe, sc_out}, {30'h0, 1'b1, pp[0]});
		n_sh = 0;
		n_sa = 0;
		watch = 1'b1;
		apb(1'b1, A_AUX, {27'h0, 2'b11, hs, a});
		for (k = 0; k < 200; k++) begin
			apb(1'b0, A_STAT, 32'h0);
			if (r[1] === 1'b1) break;
		end
		if (k == 200) begin
			n_mismatch++;
			wrap_up();
		end
		repeat (4) @(posedge pclk);
		watch = 1'b0;
		chk(32'(n_sh), 32'd8);
		chk(32'(n_sa), 32'd8);
		chk({31'h0, sc_out}, {31'h0, pp[0]});
		apb(1'b1, A_CLR, 32'h2);
	endtask : xfer

	task automatic cont(input logic [1:0] md, input logic m, input logic ie);
		logic hit;
		hit = (md == 2'b10) && m;
		apb(1'b1, A_CFG, {26'h0, md, ie, 3'b000});
		apb(1'b1, A_AUX, {28'h0, m, 3'b000});
		apb(1'b1, A_EN, 32'h1);
		far.claim();
		repeat (4) @(posedge pclk);
		apb(1'b0, A_CFG, 32'h0);
		chk(r, {26'h0, md, ie, hit, 2'b00});
		apb(1'b0, A_STAT, 32'h0);
		chk({31'h0, r[0]}, {31'h0, hit & ie});
		chk({31'h0, irq}, {31'h0, hit & ie});
		if (hit & ie) begin
			apb(1'b1, A_EN, 32'h0);
			repeat (2) @(posedge pclk);
			chk({31'h0, irq}, 32'h0);
			apb(1'b1, A_EN, 32'h1);
			repeat (2) @(posedge pclk);
			chk({31'h0, irq}, 32'h1);
			apb(1'b1, A_CLR, 32'h1);
			apb(1'b1, A_CFG, {26'h0, md, ie, 3'b000});
			repeat (2) @(posedge pclk);
			apb(1'b0, A_CFG, 32'h0);
			chk({30'h0, r[2], irq}, 32'h0);
		end
		apb(1'b1, A_EN, 32'h0);
	endtask : cont

	initial begin
		{presetn, psel, penable, pwrite, watch, master, exp_rise} = 7'h00;
		paddr = 16'h0000;
		pwdata = 32'h0;
		seed = 32'h35dd;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_CFG, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, A_STAT, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 16'h0000, 32'h0);
		chk({r[30:0], e}, 32'h1);
		apb(1'b1, A_STAT, 32'h3);
		apb(1'b0, A_STAT, 32'h0);
		chk(r, 32'h0);
		apb(1'b1, A_CFG, 32'hFF);
		apb(1'b0, A_CFG, 32'h0);
		chk(r, 32'h3B);
		for (i = 0; i < 12; i++) begin
			pp = 2'($random(seed));
			xfer(2'(i % 3), i[2], pp, 2'($random(seed)));
		end
		for (i = 0; i < 16; i++)
			cont(i[1:0], i[2], i[3]);
		master = 1'b0;
		for (i = 0; i < 4; i++) begin
			apb(1'b1, A_CFG, {30'h0, i[1:0]});
			apb(1'b1, A_AUX, 32'h0);
			far.park(i[0]);
			n_sh = 0;
			n_sa = 0;
			watch = 1'b1;
			far.frame();
			repeat (8) @(posedge pclk);
			watch = 1'b0;
			chk({sc_oe, 31'(n_sh)}, 32'd8);
			chk(32'(n_sa), 32'd8);
		end
		apb(1'b1, A_CFG, 32'h3B);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_CFG, 32'h0);
		chk(r, 32'h0);
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
